// File: common/rst_seq_regs.vh
`ifndef RST_SEQ_REGS_VH
`define RST_SEQ_REGS_VH
// register byte offsets
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_IRQ_STATUS  8'h08
`define REG_IRQ_ENABLE  8'h0c
`define REG_IRQ_CLEAR   8'h10
// control fields and reset values
`define CTRL_CLK_SRC_LSB 0
`define CTRL_CLK_SRC_W   3
`define CTRL_RESET       3'h1
// status fields
`define ST_WDT_EXPIRED   0
`define ST_SLEEP_ENTERED 1
`define ST_CAUSE_LSB     2
`define ST_STATE_LSB     4
// interrupt event bits
`define IRQ_W            5
`define IRQ_PIN          0
`define IRQ_UNDERVOLT    1
`define IRQ_WDT_RUN      2
`define IRQ_WDT_IDLE     3
`define IRQ_SEQ_DONE     4
`define IRQ_EN_RESET     5'h00
// clock sources
`define SRC_EXT_RC       3'h0
`define SRC_FAST_IRC     3'h1
`define SRC_FAST_XTAL    3'h2
`define SRC_SLOW_XTAL    3'h3
`define SRC_SLOW_IRC     3'h4
// reset causes
`define CAUSE_POWER_ON   2'h0
`define CAUSE_PIN_LV     2'h1
`define CAUSE_WDT_RUN    2'h2
`define CAUSE_WDT_IDLE   2'h3
// core modes
`define MODE_NORMAL      2'h0
`define MODE_SLOW        2'h1
`define MODE_IDLE        2'h2
`define MODE_SLEEP       2'h3
// timing
`define CLK_MHZ            125
`define POWER_ON_DELAY_MS  100
`define SST_RC_CYCLES      16
`define SST_XTAL_CYCLES    1024
`define SST_SLOW_IRC_CYCLES 2
`define LV_QUAL_CYCLES     64
// bus answers
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// File: design/lv_filter.v
`timescale 1ns/100ps
`default_nettype none
`include "rst_seq_regs.vh"
module lv_filter #(
  parameter QUAL = `LV_QUAL_CYCLES,
  parameter CW   = 16
) (
  input  wire aclk,
  input  wire aresetn,
  input  wire supply_low,
  output reg  lv_req
);
  reg [CW-1:0] cnt;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt    <= {CW{1'b0}};
      lv_req <= 1'b0;
    end else if (!supply_low) begin
      // short dips are dropped here
      cnt    <= {CW{1'b0}};
      lv_req <= 1'b0;
    end else if (cnt >= QUAL[CW-1:0]) begin
      lv_req <= 1'b1;
    end else begin
      cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
    end
  end
endmodule // lv_filter
`default_nettype wire

// File: design/mcu_reset_sequencer.v
// Behaviour
// [R1] running watchdog time-out resets like the pin and sets expiry flag
// [R2] running watchdog reset holds power-on delay then start-up count
// [R3] idle watchdog time-out clears pc and stack pointer, sets expiry flag
// [R4] start-up count 16 for rc, 1024 for crystals, 2 for slow rc
// [R5] two cause flags kept; power-on clears both
// [R6] pin or undervoltage reset leaves both cause flags unchanged
// [R7] running watchdog reset sets expiry flag, sleep flag unchanged
// [R8] idle or sleep watchdog reset sets both flags
// [R9] power-on reset disables all interrupts
// [R10] watchdog counter cleared by reset, then counts again
// [R11] power-on reset switches the timer off
// [R12] power-on reset makes ports inputs, analog pins converter inputs
// [R13] power-on reset points stack pointer at top of stack
// [R14] each reset type applies its own initial values
// [R15] pin low resets device, program counter to zero
// [R16] undervoltage reset only after low supply exceeds qualification time
// [R17] requests synchronised; release only after both counters complete
// [R18] simultaneous sources: power-on, then pin or undervoltage, then watchdog
`timescale 1ns/100ps
`default_nettype none
`include "rst_seq_regs.vh"
module mcu_reset_sequencer #(
  parameter DELAY_CYCLES = `POWER_ON_DELAY_MS * `CLK_MHZ * 1000,
  parameter CNT_W        = 24,
  parameter LV_QUAL      = `LV_QUAL_CYCLES
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ext_rst_pin_n,
  input  wire        undervoltage_rst,
  input  wire        wdt_timeout,
  input  wire [1:0]  core_mode,
  input  wire        halt_enter,
  input  wire        flag_clear,
  output reg         core_rst,
  output reg         core_stall,
  output reg         pc_clear,
  output reg         sp_clear,
  output reg         sp_to_top,
  output reg         intr_disable,
  output reg         timer_off,
  output reg         ports_input,
  output reg         adc_pins_analog,
  output reg         wdt_clear,
  output reg         wdt_expired_flag,
  output reg         sleep_entered_flag,
  output reg         irq,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);
  localparam [1:0] S_RUN   = 2'h0;
  localparam [1:0] S_HOLD  = 2'h1;
  localparam [1:0] S_DELAY = 2'h2;
  localparam [1:0] S_START = 2'h3;

  localparam integer     DELAY_M1    = DELAY_CYCLES - 1;
  localparam integer     SST_RC_M1   = `SST_RC_CYCLES - 1;
  localparam integer     SST_XTAL_M1 = `SST_XTAL_CYCLES - 1;
  localparam integer     SST_SLOW_M1 = `SST_SLOW_IRC_CYCLES - 1;
  localparam [CNT_W-1:0] DELAY_LOAD  = DELAY_M1[CNT_W-1:0];

  // start-up wait per clock source
  function [CNT_W-1:0] sst_load;
    input [2:0] src;
    begin
      case (src)
        `SRC_EXT_RC:    sst_load = SST_RC_M1[CNT_W-1:0];
        `SRC_FAST_IRC:  sst_load = SST_RC_M1[CNT_W-1:0];
        `SRC_FAST_XTAL: sst_load = SST_XTAL_M1[CNT_W-1:0];
        `SRC_SLOW_XTAL: sst_load = SST_XTAL_M1[CNT_W-1:0];
        `SRC_SLOW_IRC:  sst_load = SST_SLOW_M1[CNT_W-1:0];
        default:        sst_load = SST_RC_M1[CNT_W-1:0];
      endcase
    end
  endfunction

  function is_low_power;
    input [1:0] mode;
    begin
      is_low_power = (mode == `MODE_IDLE) || (mode == `MODE_SLEEP);
    end
  endfunction

  wire              pin_n_sync;
  wire              supply_low_sync;
  wire              lv_req;
  reg  [1:0]        state;
  reg  [CNT_W-1:0]  cnt;
  reg  [1:0]        cause;
  reg  [2:0]        clk_src;
  reg  [`IRQ_W-1:0] irq_status;
  reg  [`IRQ_W-1:0] irq_enable;
  reg  [`IRQ_W-1:0] events;
  reg  [7:0]        aw_addr;
  reg  [31:0]       w_data;
  reg  [3:0]        w_strb;
  reg  [31:0]       rd_word;
  reg               rd_ok;
  reg  [`IRQ_W-1:0] next_irq_status;

  // [R17] pin synchroniser
  sync3 #(
    .W       (1),
    .RST_VAL (1'b1)
  ) u_pin_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (ext_rst_pin_n),
    .dout    (pin_n_sync)
  );

  // [R17] supply monitor synchroniser
  sync3 #(
    .W       (1),
    .RST_VAL (1'b0)
  ) u_lv_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (undervoltage_rst),
    .dout    (supply_low_sync)
  );

  // [R16] qualification filter
  lv_filter #(
    .QUAL       (LV_QUAL),
    .CW         (16)
  ) u_lv_filter (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .supply_low (supply_low_sync),
    .lv_req     (lv_req)
  );

  wire pin_req  = ~pin_n_sync;
  wire full_req = pin_req | lv_req;

  // sequencer; aresetn acts as the power-on source
  always @(posedge aclk) begin
    if (!aresetn) begin
      // [R5] power-on clears flags
      state              <= S_DELAY;
      cnt                <= DELAY_LOAD;
      cause              <= `CAUSE_POWER_ON;
      wdt_expired_flag   <= 1'b0;
      sleep_entered_flag <= 1'b0;
      core_rst           <= 1'b1;
      core_stall         <= 1'b1;
      pc_clear           <= 1'b1;
      sp_clear           <= 1'b0;
      wdt_clear          <= 1'b1;
      events             <= {`IRQ_W{1'b0}};
    end else begin
      events   <= {`IRQ_W{1'b0}};
      pc_clear <= core_rst;
      sp_clear <= 1'b0;
      // core flag updates; set wins over clear
      if (flag_clear) begin
        wdt_expired_flag   <= 1'b0;
        sleep_entered_flag <= 1'b0;
      end
      if (halt_enter) begin
        sleep_entered_flag <= 1'b1;
      end
      case (state)
        S_RUN: begin
          // [R18] pin or undervoltage before watchdog
          if (full_req) begin
            // [R15] pin reset clears pc
            // [R6] flags left alone
            state                   <= S_HOLD;
            cause                   <= `CAUSE_PIN_LV;
            core_rst                <= 1'b1;
            core_stall              <= 1'b1;
            pc_clear                <= 1'b1;
            wdt_clear               <= 1'b1;
            events[`IRQ_PIN]        <= pin_req;
            events[`IRQ_UNDERVOLT]  <= lv_req;
          end else if (wdt_timeout && is_low_power(core_mode)) begin
            // [R3] only pc and stack pointer
            // [R8] both flags set
            state                   <= S_START;
            cnt                     <= sst_load(clk_src);
            cause                   <= `CAUSE_WDT_IDLE;
            wdt_expired_flag        <= 1'b1;
            sleep_entered_flag      <= 1'b1;
            core_stall              <= 1'b1;
            pc_clear                <= 1'b1;
            sp_clear                <= 1'b1;
            wdt_clear               <= 1'b1;
            events[`IRQ_WDT_IDLE]   <= 1'b1;
          end else if (wdt_timeout) begin
            // [R1] same as pin reset plus flag
            // [R7] expiry flag only
            // [R2] delay then start-up
            state                   <= S_DELAY;
            cnt                     <= DELAY_LOAD;
            cause                   <= `CAUSE_WDT_RUN;
            wdt_expired_flag        <= 1'b1;
            core_rst                <= 1'b1;
            core_stall              <= 1'b1;
            pc_clear                <= 1'b1;
            wdt_clear               <= 1'b1;
            events[`IRQ_WDT_RUN]    <= 1'b1;
          end
        end
        S_HOLD: begin
          // delay starts once the source is released
          if (!full_req) begin
            state <= S_DELAY;
            cnt   <= DELAY_LOAD;
          end
        end
        default: begin
          if (full_req) begin
            // [R18] power-on cause kept over pin or undervoltage
            state      <= S_HOLD;
            core_rst   <= 1'b1;
            core_stall <= 1'b1;
            wdt_clear  <= 1'b1;
            if (cause != `CAUSE_POWER_ON) begin
              cause <= `CAUSE_PIN_LV;
            end
          end else if (cnt != {CNT_W{1'b0}}) begin
            cnt <= cnt - {{(CNT_W-1){1'b0}}, 1'b1};
          end else if (state == S_DELAY) begin
            // [R4] start-up count by clock source
            state <= S_START;
            cnt   <= sst_load(clk_src);
          end else begin
            // [R17] release after both counts
            // [R10] watchdog restarts
            state                 <= S_RUN;
            core_rst              <= 1'b0;
            core_stall            <= 1'b0;
            wdt_clear             <= 1'b0;
            events[`IRQ_SEQ_DONE] <= 1'b1;
          end
        end
      endcase
    end
  end

  // [R14] initial values per reset type
  always @(posedge aclk) begin
    if (!aresetn) begin
      sp_to_top       <= 1'b1;
    end else begin
      // [R13] stack to top on full resets
      sp_to_top       <= core_rst && (cause != `CAUSE_WDT_IDLE);
    end
  end

  // [R9] interrupts disabled during full reset
  always @(posedge aclk) begin
    if (!aresetn) begin
      intr_disable    <= 1'b1;
      timer_off       <= 1'b1;
      ports_input     <= 1'b1;
      adc_pins_analog <= 1'b1;
    end else begin
      intr_disable    <= core_rst;
      // [R11] timer off
      timer_off       <= core_rst;
      // [R12] ports inputs, analog pins
      ports_input     <= core_rst;
      adc_pins_analog <= core_rst;
    end
  end

  // register read mux
  always @* begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (s_axi_araddr)
      `REG_CTRL:       rd_word[2:0] = clk_src;
      `REG_STATUS: begin
        rd_word[`ST_WDT_EXPIRED]            = wdt_expired_flag;
        rd_word[`ST_SLEEP_ENTERED]          = sleep_entered_flag;
        rd_word[`ST_CAUSE_LSB+1:`ST_CAUSE_LSB] = cause;
        rd_word[`ST_STATE_LSB+1:`ST_STATE_LSB] = state;
      end
      `REG_IRQ_STATUS: rd_word[`IRQ_W-1:0] = irq_status;
      `REG_IRQ_ENABLE: rd_word[`IRQ_W-1:0] = irq_enable;
      `REG_IRQ_CLEAR:  rd_word = 32'h0000_0000;
      default:         rd_ok = 1'b0;
    endcase
  end

  wire do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire wr_low   = do_write && w_strb[0];

  // sticky events; a new event wins over a clear
  always @* begin
    next_irq_status = irq_status;
    if (wr_low && (aw_addr == `REG_IRQ_CLEAR)) begin
      next_irq_status = irq_status & ~w_data[`IRQ_W-1:0];
    end
    next_irq_status = next_irq_status | events;
  end

  // axi4-lite slave and register file
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      clk_src       <= `CTRL_RESET;
      irq_status    <= {`IRQ_W{1'b0}};
      irq_enable    <= `IRQ_EN_RESET;
      irq           <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq        <= |(next_irq_status & irq_enable);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        case (aw_addr)
          `REG_CTRL: begin
            if (w_strb[0]) begin
              clk_src <= w_data[2:0];
            end
          end
          `REG_IRQ_ENABLE: begin
            if (w_strb[0]) begin
              irq_enable <= w_data[`IRQ_W-1:0];
            end
          end
          `REG_IRQ_CLEAR:  s_axi_bresp <= `RESP_OKAY;
          `REG_STATUS:     s_axi_bresp <= `RESP_OKAY;
          `REG_IRQ_STATUS: s_axi_bresp <= `RESP_OKAY;
          default:         s_axi_bresp <= `RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // mcu_reset_sequencer
`default_nettype wire

// File: design/sync3.v
`timescale 1ns/100ps
`default_nettype none
module sync3 #(
  parameter       W       = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s1   <= RST_VAL;
      s2   <= RST_VAL;
      s3   <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      // change accepted only once stages two and three agree
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule // sync3
`default_nettype wire

// File: verification/mcu_reset_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "rst_seq_regs.vh"
bind mcu_reset_sequencer rst_seq_properties #(.DELAY_CYCLES(DELAY_CYCLES), .LV_QUAL(LV_QUAL)) chk (
  .aclk(aclk), .aresetn(aresetn), .ext_rst_pin_n(ext_rst_pin_n),
  .undervoltage_rst(undervoltage_rst), .wdt_timeout(wdt_timeout), .core_mode(core_mode),
  .core_rst(core_rst), .core_stall(core_stall), .sp_clear(sp_clear), .sp_to_top(sp_to_top),
  .intr_disable(intr_disable), .timer_off(timer_off), .ports_input(ports_input),
  .adc_pins_analog(adc_pins_analog), .wdt_clear(wdt_clear),
  .wdt_expired_flag(wdt_expired_flag), .sleep_entered_flag(sleep_entered_flag));
module mcu_reset_sequencer_tb;
  localparam int D = 20;
  logic        aclk = 1'b0, aresetn = 1'b0, halt_enter = 1'b0, flag_clear = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, exp_to = 0, exp_pd = 0;
  wire         ext_rst_pin_n, undervoltage_rst, wdt_timeout, core_rst, core_stall, pc_clear;
  wire         sp_clear, sp_to_top, intr_disable, timer_off, ports_input, adc_pins_analog;
  wire         wdt_clear, wdt_expired_flag, sleep_entered_flag, irq, s_axi_awready;
  wire         s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]   core_mode, s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  int          fails = 0, tests_run = 0, seed = 32'hc26d, n;
  logic [31:0] rd;
  logic [1:0]  rr;
  always #4 aclk = ~aclk;
  mcu_reset_sequencer #(.DELAY_CYCLES(D), .LV_QUAL(4)) uut (
    .aclk(aclk), .aresetn(aresetn), .ext_rst_pin_n(ext_rst_pin_n),
    .undervoltage_rst(undervoltage_rst), .wdt_timeout(wdt_timeout), .core_mode(core_mode),
    .halt_enter(halt_enter), .flag_clear(flag_clear), .core_rst(core_rst),
    .core_stall(core_stall), .pc_clear(pc_clear), .sp_clear(sp_clear), .sp_to_top(sp_to_top),
    .intr_disable(intr_disable), .timer_off(timer_off), .ports_input(ports_input),
    .adc_pins_analog(adc_pins_analog), .wdt_clear(wdt_clear), .irq(irq),
    .wdt_expired_flag(wdt_expired_flag), .sleep_entered_flag(sleep_entered_flag),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  rst_src_model src (.aclk(aclk), .ext_rst_pin_n(ext_rst_pin_n), .wdt_timeout(wdt_timeout),
    .undervoltage_rst(undervoltage_rst), .core_mode(core_mode));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int t);
    if (t > 5000) begin
      fails++;
      end_sim;
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      tick(t++);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int t;
    t = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      tick(t++);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // cycles until the core runs again
  task automatic wait_run;
    n = 0;
    do begin
      @(posedge aclk);
      #1;
      tick(n++);
    end while (core_stall !== 1'b0);
  endtask
  function automatic int sst(input int s);
    return (s == 2 || s == 3) ? 1024 : (s == 4 ? 2 : 16);
  endfunction
  task automatic chk_status(input logic [1:0] cause);
    axi_rd(`REG_STATUS);
    chk("status", rd & 32'h0f, {cause, exp_pd, exp_to});
    chk("expired", wdt_expired_flag, exp_to);
    chk("sleep", sleep_entered_flag, exp_pd);
  endtask
  task automatic pulse_in(input bit h);
    @(posedge aclk);
    if (h) halt_enter <= 1'b1;
    else flag_clear <= 1'b1;
    @(posedge aclk);
    halt_enter <= 1'b0;
    flag_clear <= 1'b0;
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    #1;
    chk("rst outs", {core_rst, intr_disable, timer_off, ports_input, adc_pins_analog}, 5'h1f);
    @(posedge aclk) aresetn <= 1'b1;
    wait_run;
    chk("por time", n >= D + 16 && n <= D + 20, 1'b1);
    chk_status(`CAUSE_POWER_ON);
    axi_rd(`REG_CTRL);
    chk("ctrl", rd, `CTRL_RESET);
    axi_rd(8'h40);
    chk("unmapped resp", rr, `RESP_SLVERR);
    chk("unmapped data", rd, 32'h0);
    axi_wr(`REG_STATUS, 32'h3);
    chk("ro resp", rr, `RESP_OKAY);
    chk_status(`CAUSE_POWER_ON);
    for (int s = 0; s < 5; s++) begin
      axi_wr(`REG_CTRL, s);
      src.wdt_fire($random(seed) & 1);
      wait_run;
      exp_to = 1'b1;
      chk("wdt time", n >= D + sst(s) && n <= D + sst(s) + 4, 1'b1);
      chk_status(`CAUSE_WDT_RUN);
    end
    pulse_in(1'b1);
    exp_pd = 1'b1;
    src.pin_low(10);
    #1;
    chk("pin rst", {core_rst, pc_clear}, 2'h3);
    wait_run;
    chk_status(`CAUSE_PIN_LV);
    pulse_in(1'b0);
    {exp_to, exp_pd} = 2'h0;
    src.uv_high(2);
    repeat (12) @(posedge aclk);
    #1;
    chk("dip", core_stall, 1'b0);
    src.uv_high(14);
    wait_run;
    chk_status(`CAUSE_PIN_LV);
    src.wdt_fire(2'h2 + ($random(seed) & 1));
    #1;
    chk("idle wdt", {sp_clear, core_rst, core_stall}, 3'h5);
    wait_run;
    {exp_to, exp_pd} = 2'h3;
    chk("idle time", n <= 6, 1'b1);
    chk_status(`CAUSE_WDT_IDLE);
    axi_wr(`REG_IRQ_CLEAR, 32'h1f);
    axi_wr(`REG_IRQ_ENABLE, 32'h01);
    src.pin_low(5);
    wait_run;
    axi_rd(`REG_IRQ_STATUS);
    chk("irq stat", rd, 32'h11);
    chk("irq on", irq, 1'b1);
    axi_wr(`REG_IRQ_ENABLE, 32'h00);
    repeat (2) @(posedge aclk);
    chk("irq mask", irq, 1'b0);
    axi_wr(`REG_IRQ_CLEAR, 32'h1f);
    axi_rd(`REG_IRQ_STATUS);
    chk("irq clr", rd, 32'h0);
    end_sim;
  end
endmodule // mcu_reset_sequencer_tb
`default_nettype wire

// File: verification/rst_seq_properties.sv
`timescale 1ns/100ps
`default_nettype none
module rst_seq_properties #(
  parameter DELAY_CYCLES = 20,
  parameter LV_QUAL      = 4
) (
  input wire       aclk,
  input wire       aresetn,
  input wire       ext_rst_pin_n,
  input wire       undervoltage_rst,
  input wire       wdt_timeout,
  input wire [1:0] core_mode,
  input wire       core_rst,
  input wire       core_stall,
  input wire       sp_clear,
  input wire       sp_to_top,
  input wire       intr_disable,
  input wire       timer_off,
  input wire       ports_input,
  input wire       adc_pins_analog,
  input wire       wdt_clear,
  input wire       wdt_expired_flag,
  input wire       sleep_entered_flag
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reg [15:0] hold_n;
  reg [7:0]  lv_n;
  // length of the current reset hold and of the current low-supply run
  always @(posedge aclk) begin
    if (!aresetn || !core_rst) hold_n <= 16'h0000;
    else hold_n <= hold_n + 16'h0001;
    if (!aresetn || !undervoltage_rst) lv_n <= 8'h00;
    else if (lv_n != 8'hff) lv_n <= lv_n + 8'h01;
  end
  sequence s_wdt_ok;
    wdt_timeout && !core_stall && ext_rst_pin_n && !undervoltage_rst;
  endsequence
  sequence s_sp_pulse;
    sp_clear ##1 (!sp_clear && core_stall);
  endsequence
  property p_init;
    core_rst |=> intr_disable && timer_off && ports_input && adc_pins_analog;
  endproperty
  a_init: assert property (p_init) else $error("init outputs not held");
  property p_top; core_rst |=> sp_to_top; endproperty
  a_top: assert property (p_top) else $error("stack top not applied");
  property p_wdt_hold; core_rst |-> wdt_clear && core_stall; endproperty
  a_wdt_hold: assert property (p_wdt_hold) else $error("watchdog clear missing");
  property p_wdt_run; $fell(core_stall) |=> !wdt_clear; endproperty
  a_wdt_run: assert property (p_wdt_run) else $error("watchdog not counting");
  property p_run_wdt; s_wdt_ok and !core_mode[1] |=> core_rst && wdt_expired_flag; endproperty
  a_run_wdt: assert property (p_run_wdt) else $error("running time-out wrong");
  property p_idle_wdt; s_wdt_ok and core_mode[1] |=> s_sp_pulse; endproperty
  a_idle_wdt: assert property (p_idle_wdt) else $error("idle time-out wrong");
  property p_idle_flags; sp_clear |-> wdt_expired_flag && sleep_entered_flag && !core_rst;
  endproperty
  a_idle_flags: assert property (p_idle_flags) else $error("idle flags wrong");
  property p_pin; !ext_rst_pin_n [*8] |-> core_rst; endproperty
  a_pin: assert property (p_pin) else $error("pin reset missing");
  property p_lv; lv_n > LV_QUAL + 6 |-> core_rst; endproperty
  a_lv: assert property (p_lv) else $error("undervoltage reset missing");
  property p_release; $fell(core_rst) |-> hold_n >= DELAY_CYCLES; endproperty
  a_release: assert property (p_release) else $error("reset released early");
endmodule // rst_seq_properties
`default_nettype wire

// File: verification/rst_src_model.sv
`timescale 1ns/100ps
`default_nettype none
module rst_src_model (
  input  wire        aclk,
  output logic       ext_rst_pin_n,
  output logic       undervoltage_rst,
  output logic       wdt_timeout,
  output logic [1:0] core_mode
);
  initial begin
    ext_rst_pin_n = 1'b1;
    undervoltage_rst = 1'b0;
    wdt_timeout = 1'b0;
    core_mode = 2'h0;
  end
  task automatic pin_low(input int n);
    @(posedge aclk) ext_rst_pin_n <= 1'b0;
    repeat (n) @(posedge aclk);
    ext_rst_pin_n <= 1'b1;
  endtask
  task automatic uv_high(input int n);
    @(posedge aclk) undervoltage_rst <= 1'b1;
    repeat (n) @(posedge aclk);
    undervoltage_rst <= 1'b0;
  endtask
  // one time-out pulse with core mode set to m, mode back to normal afterwards
  task automatic wdt_fire(input logic [1:0] m);
    @(posedge aclk);
    core_mode <= m;
    wdt_timeout <= 1'b1;
    @(posedge aclk);
    wdt_timeout <= 1'b0;
    core_mode <= 2'h0;
  endtask
endmodule // rst_src_model
`default_nettype wire
